// >>> design/mis_core.sv
/*
 * instruction subset core: fetch, decode and execute of invert, decrement,
 * increment, or, moves, jump, call, returns and idle, with an 8-level return
 * stack, a 256-byte data file and an axi4-lite register slave.
 * assumes program memory answers imem_data combinationally for imem_addr on
 * the same clock; one write and one read at most under way on the bus.
 */
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "mis_defs.svh"

module mis_core (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // program memory and stack underflow pulse
    output logic [`MIS_PC_W-1:0]        imem_addr,
    input  wire logic [15:0]            imem_data,
    output logic                        stack_underflow,
    // axi4-lite slave
    input  wire logic [`MIS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`MIS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    import mis_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    mis_state_t             state_q;
    logic [`MIS_PC_W-1:0]   pc_q;
    logic [`MIS_PC_W-1:0]   pc_d;
    logic [`MIS_PC_W-1:0]   pc_inc;
    logic [`MIS_PC_W-1:0]   shadow_q;
    logic [`MIS_PC_W-1:0]   stk_q [8];
    logic [3:0]             depth_q;
    logic [7:0]             w_q;
    logic                   z_q;
    logic                   skip_q;
    logic                   run_q;
    logic                   intp_q;
    logic                   uflow_q;
    logic [15:0]            ir_q;
    logic [7:0]             ea_q;
    logic [7:0]             rf_q [`MIS_FILE_WORDS];

    // decode and execute results
    logic                   go_second;
    logic                   do_exec;
    logic [15:0]            ins;
    logic [7:0]             ea;
    logic [7:0]             opnd;
    logic [7:0]             res;
    logic                   fw_en;
    logic [7:0]             fw_a;
    logic [7:0]             fw_d;
    logic                   w_we;
    logic [7:0]             w_d;
    logic                   z_we;
    logic                   skip_set;
    logic                   push;
    logic                   pop;
    logic                   uflow_ev;
    logic                   intp_clr;
    logic                   stall;

    // bus side
    logic                   aw_have_q;
    logic                   w_have_q;
    logic [`MIS_ADDR_W-1:0] aw_q;
    logic [31:0]            wd_q;
    logic [3:0]             ws_q;
    logic                   bus_wr;
    logic [31:0]            rd_word;
    logic                   rd_hit;
    logic                   wr_hit;

    // data file read with working and status aliases
    function automatic logic [7:0] file_rd(input logic [7:0] a);
        logic [7:0] v;
        v = rf_q[a];
        if (a == `MIS_FILE_WREG)
            v = w_q;
        else if (a == `MIS_FILE_STATUS)
            v = {7'h00, z_q};
        return v;
    endfunction : file_rd

    // two-cycle forms: indirect register ops, long moves, call
    function automatic logic needs_two(input logic [15:0] i);
        return (i[15:12] == 4'h1 && i[7]) || i[15] || i[15:13] == 3'b011;
    endfunction : needs_two

    assign pc_inc    = pc_q + `MIS_PC_W'(1);
    assign imem_addr = pc_q;
    assign stall     = !run_q || skip_q;
    assign go_second = state_q == MIS_EXEC && !stall && needs_two(imem_data);
    assign do_exec   = (state_q == MIS_EXEC && !stall && !go_second) || state_q == MIS_SECOND;
    assign ins       = (state_q == MIS_SECOND) ? ir_q : imem_data;
    assign ea        = (state_q == MIS_SECOND) ? ea_q : {2'b00, imem_data[5:0]};

    // operand fetch in a process, so a file write is seen even when ea stays put
    always_comb begin
        opnd = file_rd(ea);
    end

    // ------------------------------------------------------------------------
    // decode and execute
    // ------------------------------------------------------------------------
    // one combinational pass yields every write of the instruction in flight
    always_comb begin
        res      = opnd;
        fw_en    = 1'b0;
        fw_a     = ea;
        fw_d     = res;
        w_we     = 1'b0;
        w_d      = res;
        z_we     = 1'b0;
        skip_set = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        uflow_ev = 1'b0;
        intp_clr = 1'b0;
        pc_d     = pc_q;
        if (state_q == MIS_EXEC && skip_q) begin
            pc_d = pc_inc;
        end else if (do_exec) begin
            pc_d = pc_inc;
            if (ins[15:14] == 2'b11) begin
                fw_a  = ins[13:6];
                fw_d  = file_rd({2'b00, ins[5:0]});
                fw_en = 1'b1;
            end else if (ins[15:14] == 2'b10) begin
                fw_a  = {2'b00, ins[5:0]};
                fw_d  = file_rd(ins[13:6]);
                fw_en = 1'b1;
            end else if (ins[15:13] == 3'b010) begin
                pc_d = ins[12:0];
            end else if (ins[15:13] == 3'b011) begin
                pc_d = ins[12:0];
                push = 1'b1;
            end else begin
                case (ins[15:8])
                    MIS_OP_INV: res = ~opnd;
                    MIS_OP_DEC, MIS_OP_DECSKIP: res = opnd - 8'h01;
                    MIS_OP_INC, MIS_OP_INCSKIP: res = opnd + 8'h01;
                    MIS_OP_ORREG: res = w_q | opnd;
                    MIS_OP_ORLIT: res = w_q | ins[7:0];
                    MIS_OP_LDLIT, MIS_OP_RETLIT: res = ins[7:0];
                    default: res = opnd;
                endcase
                fw_d = res;
                w_d  = res;
                case (ins[15:8])
                    MIS_OP_INV, MIS_OP_DEC, MIS_OP_DECSKIP, MIS_OP_INC,
                    MIS_OP_INCSKIP, MIS_OP_ORREG: begin
                        fw_en    = ins[6];
                        w_we     = !ins[6];
                        z_we     = ins[15:8] != MIS_OP_INCSKIP;
                        skip_set = (ins[15:8] == MIS_OP_DECSKIP ||
                                    ins[15:8] == MIS_OP_INCSKIP) && res == 8'h00;
                    end
                    MIS_OP_LDWORK: begin
                        w_we = 1'b1;
                        z_we = 1'b1;
                    end
                    MIS_OP_STWORK: begin
                        fw_en = 1'b1;
                        fw_d  = w_q;
                    end
                    MIS_OP_ORLIT: begin
                        w_we = 1'b1;
                        z_we = 1'b1;
                    end
                    MIS_OP_LDLIT: w_we = 1'b1;
                    MIS_OP_RETLIT, MIS_OP_RET: begin
                        w_we     = ins[15:8] == MIS_OP_RETLIT;
                        pop      = depth_q != `MIS_RST_DEPTH;
                        uflow_ev = depth_q == `MIS_RST_DEPTH;
                        if (pop)
                            pc_d = stk_q[3'(depth_q - 4'h1)];
                    end
                    MIS_OP_IRET: begin
                        pc_d     = shadow_q;
                        intp_clr = 1'b1;
                    end
                    default: pc_d = pc_inc;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    // second cycle holds the instruction and its resolved operand address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= MIS_EXEC;
            ir_q    <= 16'h0000;
            ea_q    <= `MIS_RST_BYTE;
        end else begin
            case (state_q)
                MIS_EXEC: begin
                    if (go_second) begin
                        state_q <= MIS_SECOND;
                        ir_q    <= imem_data;
                        if (imem_data[15:12] == 4'h1 && imem_data[7])
                            ea_q <= file_rd({2'b00, imem_data[5:0]});
                        else
                            ea_q <= {2'b00, imem_data[5:0]};
                    end
                end
                MIS_SECOND: state_q <= MIS_EXEC;
                default: state_q <= MIS_EXEC;
            endcase
        end
    end

    // program counter and skip marker
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q   <= `MIS_RST_PC;
            skip_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            if (skip_set)
                skip_q <= 1'b1;
            else if (state_q == MIS_EXEC && skip_q)
                skip_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // working register, zero flag and data file
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            w_q <= `MIS_RST_BYTE;
        else if (w_we)
            w_q <= w_d;
        else if (fw_en && fw_a == `MIS_FILE_WREG)
            w_q <= fw_d;
    end

    // flag update of the instruction outranks a file write to status
    always_ff @(posedge aclk) begin
        if (!aresetn)
            z_q <= 1'b0;
        else if (z_we)
            z_q <= res == 8'h00;
        else if (fw_en && fw_a == `MIS_FILE_STATUS)
            z_q <= fw_d[`MIS_FILE_Z_BIT];
    end

    // file storage, no reset: contents are software's
    always_ff @(posedge aclk) begin
        if (fw_en && fw_a != `MIS_FILE_WREG && fw_a != `MIS_FILE_STATUS)
            rf_q[fw_a] <= fw_d;
    end

    // ------------------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------------------
    // a push on a full stack is dropped and the depth stays at eight
    always_ff @(posedge aclk) begin
        if (!aresetn)
            depth_q <= `MIS_RST_DEPTH;
        else if (push && depth_q != `MIS_STACK_DEPTH)
            depth_q <= depth_q + 4'h1;
        else if (pop)
            depth_q <= depth_q - 4'h1;
    end

    generate
        for (genvar g = 0; g < 8; g++) begin : g_stk
            always_ff @(posedge aclk) begin
                if (!aresetn)
                    stk_q[g] <= `MIS_RST_PC;
                else if (push && depth_q == 4'(g))
                    stk_q[g] <= pc_inc;
            end
        end
    endgenerate

    // underflow pulse and sticky bit; a new event wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stack_underflow <= 1'b0;
            uflow_q         <= 1'b0;
        end else begin
            stack_underflow <= uflow_ev;
            if (uflow_ev)
                uflow_q <= 1'b1;
            else if (bus_wr && aw_q == `MIS_OFF_STATUS && ws_q[0] &&
                     wd_q[`MIS_ST_UFLOW_BIT])
                uflow_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------------
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign bus_wr        = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit        = aw_q == `MIS_OFF_CTRL || aw_q == `MIS_OFF_STATUS ||
                           aw_q == `MIS_OFF_SHADOW;

    // address and data are caught in either order, then applied together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_q         <= `MIS_RST_BYTE;
            wd_q         <= 32'h0000_0000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MIS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q      <= {s_axi_awaddr[`MIS_ADDR_W-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_q     <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end
            if (bus_wr) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `MIS_RESP_OKAY : `MIS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control: run enable and in-progress set; set wins over the return's clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q  <= 1'b0;
            intp_q <= 1'b0;
        end else begin
            if (bus_wr && aw_q == `MIS_OFF_CTRL && ws_q[0])
                run_q <= wd_q[`MIS_CTRL_RUN_BIT];
            if (bus_wr && aw_q == `MIS_OFF_CTRL && ws_q[0] && wd_q[`MIS_CTRL_INTP_BIT])
                intp_q <= 1'b1;
            else if (intp_clr)
                intp_q <= 1'b0;
        end
    end

    // shadow program counter, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_q <= `MIS_RST_PC;
        end else if (bus_wr && aw_q == `MIS_OFF_SHADOW) begin
            if (ws_q[0])
                shadow_q[7:0] <= wd_q[7:0];
            if (ws_q[1])
                shadow_q[12:8] <= wd_q[12:8];
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------------
    // read mux; unmapped offsets answer zero with slverr
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case ({s_axi_araddr[`MIS_ADDR_W-1:2], 2'b00})
            `MIS_OFF_CTRL:   rd_word[`MIS_CTRL_RUN_BIT] = run_q;
            `MIS_OFF_STATUS: begin
                rd_word[`MIS_ST_ZERO_BIT]   = z_q;
                rd_word[`MIS_ST_INTP_BIT]   = intp_q;
                rd_word[`MIS_ST_UFLOW_BIT]  = uflow_q;
                rd_word[`MIS_ST_SECOND_BIT] = state_q == MIS_SECOND;
                rd_word[`MIS_ST_DEPTH_LSB +: 4] = depth_q;
            end
            `MIS_OFF_PC:     rd_word[`MIS_PC_W-1:0] = pc_q;
            `MIS_OFF_WREG:   rd_word[7:0] = w_q;
            `MIS_OFF_SHADOW: rd_word[`MIS_PC_W-1:0] = shadow_q;
            default:         rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // one read at a time, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `MIS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `MIS_RESP_OKAY : `MIS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : mis_core
`default_nettype wire

// >>> design/mis_defs.svh
/*
 * constants of the instruction subset core: register offsets, field positions,
 * reset values, data file aliases and stack sizing.
 * assumes inclusion by bare name from the core and its package users.
 */
`ifndef MIS_DEFS_SVH
`define MIS_DEFS_SVH

// ----------------------------------------------------------------------------
// bus register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define MIS_ADDR_W         8
`define MIS_OFF_CTRL       8'h00
`define MIS_OFF_STATUS     8'h04
`define MIS_OFF_PC         8'h08
`define MIS_OFF_WREG       8'h0C
`define MIS_OFF_SHADOW     8'h10

// ----------------------------------------------------------------------------
// register fields
// ----------------------------------------------------------------------------
`define MIS_CTRL_RUN_BIT   0
`define MIS_CTRL_INTP_BIT  1
`define MIS_ST_ZERO_BIT    0
`define MIS_ST_INTP_BIT    1
`define MIS_ST_UFLOW_BIT   2
`define MIS_ST_SECOND_BIT  3
`define MIS_ST_DEPTH_LSB   4
`define MIS_FILE_Z_BIT     0
`define MIS_RESP_OKAY      2'h0
`define MIS_RESP_SLVERR    2'h2

// ----------------------------------------------------------------------------
// data file aliases, widths, stack
// ----------------------------------------------------------------------------
`define MIS_FILE_WREG      8'h00
`define MIS_FILE_STATUS    8'h01
`define MIS_PC_W           13
`define MIS_STACK_DEPTH    4'h8
`define MIS_FILE_WORDS     256

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MIS_RST_PC         13'h0000
`define MIS_RST_BYTE       8'h00
`define MIS_RST_DEPTH      4'h0

`endif

// >>> design/mis_pkg.sv
/*
 * types of the instruction subset core: sequencer states and opcode bytes.
 * assumes nothing of its surroundings.
 */
package mis_pkg;

    // ------------------------------------------------------------------------
    // sequencer states and upper opcode byte of register and literal forms
    // ------------------------------------------------------------------------
    typedef enum logic { MIS_EXEC, MIS_SECOND } mis_state_t;

    typedef enum logic [7:0] {
        MIS_OP_IDLE     = 8'h01,
        MIS_OP_IRET     = 8'h04,
        MIS_OP_RETLIT   = 8'h05,
        MIS_OP_RET      = 8'h07,
        MIS_OP_ORLIT    = 8'h09,
        MIS_OP_LDLIT    = 8'h0A,
        MIS_OP_INV      = 8'h13,
        MIS_OP_DEC      = 8'h14,
        MIS_OP_DECSKIP  = 8'h15,
        MIS_OP_INC      = 8'h16,
        MIS_OP_INCSKIP  = 8'h17,
        MIS_OP_LDWORK   = 8'h18,
        MIS_OP_ORREG    = 8'h19,
        MIS_OP_STWORK   = 8'h1B
    } mis_op_t;

endpackage : mis_pkg

// >>> tb/mis_core_asserts.sv
/* checker: timing relations at the mis_core ports.
   assumes a bind onto mis_core and a single clock domain. */
`timescale 1ns/10ps
`default_nettype none
`include "mis_defs.svh"
module mis_core_asserts (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic [`MIS_PC_W-1:0] imem_addr,
    input wire logic [15:0]          imem_data,
    input wire logic                 stack_underflow,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------------
    // program flow
    // ------------------------------------------------------------------
    property p_jump;
        !$stable(imem_addr) && $past(imem_data[15:13]) == 3'h2 && imem_addr != $past(imem_addr) + 13'h1
        |-> imem_addr == $past(imem_data[12:0]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_single;
        !$stable(imem_addr) && $past(imem_data[15:8]) inside {8'h01, 8'h09, 8'h0A}
        |-> imem_addr == $past(imem_addr) + 13'h1;
    endproperty
    a_single: assert property (p_single) else $error("one-cycle op misplaced pc");
    property p_indir;
        !$stable(imem_addr) && $past(imem_data[15:12]) == 4'h1 && $past(imem_data[7])
        && $past(imem_data[11:8]) inside {[4'h3:4'h9], 4'hB} |-> $past(imem_addr, 2) == $past(imem_addr);
    endproperty
    a_indir: assert property (p_indir) else $error("indirect op took one cycle");
    property p_uf;
        stack_underflow |-> $past(imem_data[15:8]) inside {8'h05, 8'h07};
    endproperty
    a_uf: assert property (p_uf) else $error("underflow without return");
    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    property p_rafter;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rafter: assert property (p_rafter) else $error("read answer late");
    property p_rblock;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rblock: assert property (p_rblock) else $error("read taken while busy");
    property p_rdrop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer repeated");
    property p_bdrop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer repeated");
    c_uf: cover property (stack_underflow);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_jmp: cover property (!$stable(imem_addr) && $past(imem_data[15:13]) == 3'h2);
endmodule : mis_core_asserts
bind mis_core mis_core_asserts u_chk (.aclk, .aresetn, .imem_addr, .imem_data, .stack_underflow,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// >>> tb/mis_prog_mem.sv
/* program memory model: 8k words, combinational read.
   assumes the bench loads words through the load port while halted. */
`timescale 1ns/10ps
`default_nettype none
module mis_prog_mem (
    input  wire logic        aclk,
    input  wire logic [12:0] imem_addr,
    output logic [15:0]      imem_data,
    input  wire logic        ld_en,
    input  wire logic [12:0] ld_addr,
    input  wire logic [15:0] ld_data
);
    logic [15:0] mem_q [0:8191];
    // unloaded words read as idle
    initial for (int i = 0; i < 8192; i++) mem_q[i] = 16'h0101;
    always @(posedge aclk) if (ld_en) mem_q[ld_addr] <= ld_data;
    assign imem_data = mem_q[imem_addr];
endmodule : mis_prog_mem
`default_nettype wire

// >>> tb/test_mis_core_instruction_subset.sv
/* testbench for mis_core: reset values, bus errors and a program run.
   assumes mis_prog_mem as program memory and a 100 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
`include "mis_defs.svh"
module test_mcu_core_instruction_subset;
    logic        aclk = 1'b0, aresetn = 1'b0, ld_en = 1'b0, uflow;
    logic [12:0] imem_addr, ld_addr = 13'h0000;
    logic [15:0] imem_data, ld_data = 16'h0000;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          fail_count = 0, check_count = 0, cyc = 0, uf_n = 0;
    mis_core dut (.aclk(aclk), .aresetn(aresetn), .imem_addr(imem_addr), .imem_data(imem_data),
        .stack_underflow(uflow), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    mis_prog_mem u_mem (.aclk(aclk), .imem_addr(imem_addr), .imem_data(imem_data),
        .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data));
    always #5 aclk = ~aclk;
    // cycle limit and underflow pulse count
    always @(posedge aclk) begin
        cyc++;
        if (uflow === 1'b1) uf_n++;
        if (cyc == 3000) begin
            fail_count++;
            $display("Error %0t timeout", $time);
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad = 1'b0, wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready && !ad) awvalid <= 1'b0;
            if (wready && !wd) wvalid <= 1'b0;
            ad = ad | awready;
            wd = wd | wready;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk); // idle edge: bready never driven twice in one step
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk); // idle edge: rready never driven twice in one step
    endtask : axi_rd
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        axi_rd(`MIS_OFF_PC, 32'h0, `MIS_RESP_OKAY);
        axi_rd(`MIS_OFF_STATUS, 32'h0, `MIS_RESP_OKAY);
        axi_rd(8'h40, 32'h0, `MIS_RESP_SLVERR);
        axi_wr(8'h40, 32'h5, `MIS_RESP_SLVERR);
    endtask : t_reset
    task automatic t_program();
        logic [15:0] prog [0:33] = '{16'h0500, 16'h0101, 16'h0700, 16'h0A05, 16'h1B20, 16'h1560,
            16'h4005, 16'h0AFF, 16'h1B21, 16'h1761, 16'h403F, 16'h1320, 16'h1660, 16'h1460,
            16'h0900, 16'h0A22, 16'h1B30, 16'h0A00, 16'h1B22, 16'h18F0, 16'h0A0F, 16'h19F0,
            16'h88A3, 16'hE023, 16'h0A80, 16'h1B31, 16'h18F1, 16'h6020, 16'h0400, 16'h403F,
            16'h401E, 16'h0101, 16'h0101, 16'h0700};
        foreach (prog[i]) begin
            ld_addr <= 13'(i);
            ld_data <= prog[i];
            ld_en <= 1'b1;
            @(posedge aclk);
        end
        ld_en <= 1'b0;
        axi_wr(`MIS_OFF_SHADOW, 32'h1E, `MIS_RESP_OKAY);
        axi_wr(`MIS_OFF_CTRL, 32'h3, `MIS_RESP_OKAY);
        repeat (300) @(posedge aclk);
        axi_rd(`MIS_OFF_PC, 32'h1E, `MIS_RESP_OKAY);
        axi_rd(`MIS_OFF_WREG, 32'h0F, `MIS_RESP_OKAY);
        axi_rd(`MIS_OFF_STATUS, 32'h04, `MIS_RESP_OKAY);
        chk(uf_n, 32'd2);
    endtask : t_program
    // reset, then scenarios, then verdict
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_program();
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
endmodule : test_mcu_core_instruction_subset
`default_nettype wire
